// ---- hw/sasi_target_host_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module sasi_target_host_port #(
	parameter int ADDR = sasi_pkg::TARGET_ADDR,
	parameter int DEPTH = sasi_pkg::BUF_DEPTH
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic SEL_N,
	input wire logic ACK_N,
	input wire logic [7:0] DB_N_IN,
	output logic [7:0] DB_N_OUT,
	output logic DB_N_OE,
	output logic BUSY_N,
	output logic REQ_N,
	output logic IO_N,
	output logic CD_N,
	output logic MSG_N,
	output logic CMD_VALID,
	output logic [47:0] CMD_BLOCK,
	input wire logic XFER_START,
	input wire logic XFER_TO_HOST,
	input wire logic [15:0] XFER_LEN,
	input wire logic STATUS_VALID,
	input wire logic [7:0] STATUS_BYTE,
	output logic STATUS_READY,
	input wire logic [7:0] DISK_WDATA,
	input wire logic DISK_WVALID,
	output logic DISK_WREADY,
	output logic [7:0] DISK_RDATA,
	output logic DISK_RVALID,
	input wire logic DISK_RREADY
);
	import sasi_pkg::*;

	typedef enum {S_IDLE, S_CMD, S_PLAN, S_DATA, S_STAT_WAIT, S_STAT, S_DONE} state_t;

	state_t state;
	phase_t phase;
	logic req;
	logic busy;
	logic to_host;
	logic [15:0] cnt;
	logic [15:0] len;
	logic [5:0] settle;
	logic [7:0] dout;
	logic [7:0] stat;
	logic [47:0] cmd;
	logic cmd_valid;

	wire [7:0] host_byte = ~DB_N_IN;
	wire selected = !SEL_N && !DB_N_IN[ADDR];
	wire in_xfer = (state == S_CMD) || (state == S_DATA) || (state == S_STAT) || (state == S_DONE);

	logic buf_in_ready;
	logic buf_out_valid;
	logic [7:0] buf_out_data;
	wire data_phase = (state == S_DATA);
	wire byte_ready = !data_phase || (to_host ? buf_out_valid : buf_in_ready);
	// A new byte is only offered once the host has let go of the previous ACK
	wire raise = in_xfer && !req && ACK_N && byte_ready;
	// Host data is given its settling time before it is sampled
	wire take = req && !ACK_N && (settle == 6'(DATA_SETTLE_CYC - 1));
	wire last_cmd = (cnt == CMD_LEN - 16'h0001);
	wire last_data = (cnt == len - 16'h0001);
	wire plan_data = XFER_START && (XFER_LEN != 16'h0000);

	// Both directions share one buffer; the disk side only ever sees one end
	wire buf_push_src = to_host ? (DISK_WVALID && data_phase) : (take && data_phase);
	wire buf_pop = to_host ? (raise && data_phase) : (DISK_RREADY && !data_phase);
	wire [7:0] buf_in_data = to_host ? DISK_WDATA : host_byte;

	sector_buffer #(
		.WIDTH(BYTE_W),
		.DEPTH(DEPTH)
	) u_buf (
		.MCLK(MCLK),
		.RST_N(RST_N),
		.IN_DATA(buf_in_data),
		.IN_VALID(buf_push_src),
		.IN_READY(buf_in_ready),
		.OUT_DATA(buf_out_data),
		.OUT_VALID(buf_out_valid),
		.OUT_READY(buf_pop)
	);

	assign DISK_WREADY = to_host && data_phase && buf_in_ready;
	assign DISK_RDATA = buf_out_data;
	assign DISK_RVALID = !to_host && !data_phase && buf_out_valid;
	assign STATUS_READY = (state == S_PLAN) || (state == S_STAT_WAIT);

	assign REQ_N = !req;
	assign BUSY_N = !busy;
	assign IO_N = phase.io_n;
	assign CD_N = phase.cd_n;
	assign MSG_N = phase.msg_n;
	assign DB_N_OUT = ~dout;
	// Bus is driven only while I/O says the target owns it
	assign DB_N_OE = busy && !phase.io_n;
	assign CMD_VALID = cmd_valid;
	assign CMD_BLOCK = cmd;

	always_ff @(posedge MCLK) begin
		if (!RST_N || !req || ACK_N) begin
			settle <= '0;
		end else if (!take) begin
			settle <= settle + 6'h01;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			req <= 1'b0;
			dout <= 8'h00;
		end else if (raise) begin
			req <= 1'b1;
			if (state == S_STAT) begin
				dout <= stat;
			end else if (state == S_DONE) begin
				dout <= DONE_BYTE;
			end else if (data_phase && to_host) begin
				dout <= buf_out_data;
			end
		end else if (take) begin
			req <= 1'b0;
		end
	end

	// Phase lines only move between bytes, never while REQ qualifies them
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			state <= S_IDLE;
			phase <= PH_RESET;
			busy <= 1'b0;
			to_host <= 1'b0;
			cnt <= 16'h0000;
			len <= 16'h0000;
			stat <= 8'h00;
			cmd <= '0;
			cmd_valid <= 1'b0;
		end else begin
			cmd_valid <= 1'b0;
			case (state)
				S_IDLE: begin
					if (selected) begin
						busy <= 1'b1;
						phase <= PH_CMD;
						cnt <= 16'h0000;
						state <= S_CMD;
					end
				end
				S_CMD: begin
					if (take) begin
						cmd <= {cmd[39:0], host_byte};
						cnt <= cnt + 16'h0001;
						if (last_cmd) begin
							cmd_valid <= 1'b1;
							state <= S_PLAN;
						end
					end
				end
				S_PLAN: begin
					if (plan_data) begin
						len <= XFER_LEN;
						to_host <= XFER_TO_HOST;
						cnt <= 16'h0000;
						phase <= XFER_TO_HOST ? PH_DATA_IN : PH_DATA_OUT;
						state <= S_DATA;
					end else if (STATUS_VALID) begin
						stat <= STATUS_BYTE;
						phase <= PH_STATUS;
						state <= S_STAT;
					end
				end
				S_DATA: begin
					if (take) begin
						cnt <= cnt + 16'h0001;
						if (last_data) begin
							state <= S_STAT_WAIT;
						end
					end
				end
				S_STAT_WAIT: begin
					if (STATUS_VALID) begin
						stat <= STATUS_BYTE;
						phase <= PH_STATUS;
						state <= S_STAT;
					end
				end
				S_STAT: begin
					if (take) begin
						phase <= PH_DONE;
						state <= S_DONE;
					end
				end
				S_DONE: begin
					if (take) begin
						busy <= 1'b0;
						phase <= PH_RESET;
						state <= S_IDLE;
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	localparam int REQ_BOUND = 4;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	sequence s_raise;
		!req ##1 req;
	endsequence

	sequence s_enter_cmd;
		state != S_CMD ##1 state == S_CMD;
	endsequence

	a_busy_select: assert property ($rose(busy) |-> $past(selected) && $past(state == S_IDLE))
		else $error("busy without selection");
	a_busy_hold: assert property (busy && state != S_DONE |=> busy)
		else $error("busy dropped before completion");
	a_req_ack_free: assert property (s_raise |-> $past(ACK_N))
		else $error("request raised while ack low");
	a_req_until_ack: assert property (req && ACK_N |=> req)
		else $error("request dropped without ack");
	a_take_settled: assert property ($fell(req) |-> $past(!ACK_N, DATA_SETTLE_CYC))
		else $error("byte sampled before settle time");
	a_phase_stable: assert property (req |=> $stable(phase) || !req)
		else $error("phase moved under request");
	// Ties the bus owner to the transfer direction, not to the enable expression
	a_io_owner: assert property (req |-> DB_N_OE == !IO_N &&
		IO_N == (state == S_CMD || (data_phase && !to_host)))
		else $error("io level does not match bus owner");
	a_cmd_phase: assert property (req && state == S_CMD |-> phase == PH_CMD)
		else $error("wrong command phase code");
	a_cmd_req_soon: assert property (s_enter_cmd |-> ##[1:REQ_BOUND] req)
		else $error("command request late");
	a_cmd_block: assert property (state == S_CMD && take && cnt == 16'h0005 |=> CMD_VALID)
		else $error("command block not reported after six bytes");
	a_done_byte: assert property (req && state == S_DONE |-> phase == PH_DONE && dout == 8'h00)
		else $error("completion byte wrong");
	a_reset_idle: assert property (disable iff (1'b0) !RST_N |=> state == S_IDLE && !req && !busy)
		else $error("reset did not idle");
endmodule
`default_nettype wire

// ---- hw/sasi_pkg.sv ----
// How it works
// - I/O low when we drive bus
// - C/D low command/status, high data
// - Phase lines valid only while REQ asserted
// - Five phase encodings on I/O, C/D, MSG
// - BUSY only on SEL plus address bit
// - One REQ per byte, both directions
// - Reset returns to idle, clears status
// - Eight active-low lines, line zero LSB
// - Data line n addresses controller n
// - Stage transfers through 1K-byte buffer
// - REQ within 10 us of command phase
// - Command block is six bytes
// - Two status bytes, second is zero
package sasi_pkg;
	typedef struct packed {
		logic io_n;
		logic cd_n;
		logic msg_n;
	} phase_t;

	localparam phase_t PH_CMD = 3'b101;
	localparam phase_t PH_DATA_OUT = 3'b111;
	localparam phase_t PH_DATA_IN = 3'b011;
	localparam phase_t PH_STATUS = 3'b001;
	localparam phase_t PH_DONE = 3'b000;
	localparam phase_t PH_RESET = 3'b111;

	localparam int TARGET_ADDR = 0;
	localparam logic [15:0] CMD_LEN = 16'h0006;
	localparam int BUF_DEPTH = 1024;
	localparam int BYTE_W = 8;
	localparam logic [7:0] DONE_BYTE = 8'h00;

	localparam int CLK_PERIOD_NS = 5;
	localparam int DATA_SETTLE_NS = 250;
	localparam int DATA_SETTLE_CYC = (DATA_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REQ_DELAY_US = 10;
	localparam int REQ_DELAY_CYC = (REQ_DELAY_US * 1000) / CLK_PERIOD_NS;
endpackage

// ---- hw/sector_buffer.sv ----
`timescale 1ns/1ps
`default_nettype none
module sector_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 1024
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [WIDTH-1:0] IN_DATA,
	input wire logic IN_VALID,
	output logic IN_READY,
	output logic [WIDTH-1:0] OUT_DATA,
	output logic OUT_VALID,
	input wire logic OUT_READY
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wptr;
	logic [AW:0] rptr;
	wire push = IN_VALID && IN_READY;
	wire pop = OUT_VALID && OUT_READY;
	wire empty = (wptr == rptr);
	wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);

	assign IN_READY = !full;
	assign OUT_VALID = !empty;
	assign OUT_DATA = mem[rptr[AW-1:0]];

	always_ff @(posedge MCLK) begin
		if (push) begin
			mem[wptr[AW-1:0]] <= IN_DATA;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			wptr <= '0;
			rptr <= '0;
		end else begin
			wptr <= wptr + (AW+1)'(push);
			rptr <= rptr + (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// ---- tb/sasi_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sasi_host_model (
	input wire logic MCLK,
	input wire logic REQ_N,
	input wire logic IO_N,
	input wire logic BUSY_N,
	input wire logic [7:0] DB_N_OUT,
	input wire logic DB_N_OE,
	output logic SEL_N,
	output logic ACK_N,
	output logic [7:0] DB_N_IN
);
	logic [7:0] tx_q[$];
	logic [7:0] drv_n = 8'hFF;
	logic oe = 1'b0;
	// Terminators pull an undriven line high
	assign DB_N_IN = DB_N_OE ? DB_N_OUT : (oe ? drv_n : 8'hFF);
	initial begin
		bit mine;
		SEL_N = 1'b1;
		ACK_N = 1'b1;
		forever begin
			@(posedge MCLK);
			#1;
			if (REQ_N === 1'b0) begin
				// Random latency so both prompt and slow hosts are seen
				repeat ($urandom_range(3)) begin
					@(posedge MCLK);
					#1;
				end
				mine = (IO_N === 1'b1);
				if (mine) begin
					drv_n = ~tx_q.pop_front();
					oe = 1'b1;
				end
				ACK_N = 1'b0;
				// Byte stays put until the target lets go of its request
				while (REQ_N !== 1'b1) begin
					@(posedge MCLK);
					#1;
				end
				ACK_N = 1'b1;
				// A selection may already have claimed the bus in this step
				if (mine) begin
					oe = 1'b0;
				end
			end
		end
	end
	task automatic select(input int n);
		drv_n = ~(8'h01 << n);
		oe = 1'b1;
		SEL_N = 1'b0;
		for (int i = 0; i < 20; i++) begin
			@(posedge MCLK);
			#1;
			if (BUSY_N === 1'b0) break;
		end
		SEL_N = 1'b1;
		oe = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- tb/sasi_target_host_port_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sasi_target_host_port_tb_top;
	import sasi_pkg::*;
	logic mclk, rst_n, sel_n, ack_n, db_n_oe, busy_n, req_n, io_n, cd_n, msg_n, cmd_valid;
	logic xfer_start, xfer_to_host, status_valid, status_ready;
	logic disk_wvalid, disk_wready, disk_rvalid, disk_rready;
	logic [7:0] db_n_in, db_n_out, status_byte, disk_wdata, disk_rdata;
	logic [15:0] xfer_len;
	logic [47:0] cmd_block, seen_byte;
	logic [47:0] exp_q[$];
	logic [47:0] disk_exp[$];
	logic [47:0] ph_q[$];
	logic [7:0] feed_q[$];
	int num_errors = 0;
	int checks_done = 0;
	sasi_target_host_port DUT (.MCLK(mclk), .RST_N(rst_n), .SEL_N(sel_n), .ACK_N(ack_n),
		.DB_N_IN(db_n_in), .DB_N_OUT(db_n_out), .DB_N_OE(db_n_oe), .BUSY_N(busy_n),
		.REQ_N(req_n), .IO_N(io_n), .CD_N(cd_n), .MSG_N(msg_n), .CMD_VALID(cmd_valid),
		.CMD_BLOCK(cmd_block), .XFER_START(xfer_start), .XFER_TO_HOST(xfer_to_host),
		.XFER_LEN(xfer_len), .STATUS_VALID(status_valid), .STATUS_BYTE(status_byte),
		.STATUS_READY(status_ready), .DISK_WDATA(disk_wdata), .DISK_WVALID(disk_wvalid),
		.DISK_WREADY(disk_wready), .DISK_RDATA(disk_rdata), .DISK_RVALID(disk_rvalid),
		.DISK_RREADY(disk_rready));
	sasi_host_model host (.MCLK(mclk), .REQ_N(req_n), .IO_N(io_n), .BUSY_N(busy_n),
		.DB_N_OUT(db_n_out), .DB_N_OE(db_n_oe), .SEL_N(sel_n), .ACK_N(ack_n), .DB_N_IN(db_n_in));
	assign seen_byte = 48'({db_n_oe, io_n, cd_n, msg_n, ~db_n_out});
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("Checks %0d, errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Phase, and data on to-host bytes, are judged together as REQ_N falls
	always @(negedge req_n) begin
		#1;
		if (io_n === 1'b0) begin
			check("to-host", seen_byte, exp_q.pop_front());
		end else begin
			check("from-host phase", 48'({io_n, cd_n, msg_n}), ph_q.pop_front());
		end
	end
	// Mid-cycle, the values that the next rising edge acts on have settled
	always @(negedge mclk) begin
		if (cmd_valid === 1'b1) check("command", cmd_block, exp_q.pop_front());
		if (disk_rvalid === 1'b1 && disk_rready === 1'b1) begin
			check("disk", 48'(disk_rdata), disk_exp.pop_front());
		end
		if (disk_wvalid === 1'b1 && disk_wready === 1'b1) void'(feed_q.pop_front());
	end
	always @(posedge mclk) begin
		#1;
		disk_rready = 1'($urandom);
		disk_wvalid = feed_q.size() > 0 && (disk_wvalid || 1'($urandom));
		disk_wdata = feed_q.size() > 0 ? feed_q[0] : 8'h00;
	end
	task automatic run(input bit to_host, input int len);
		logic [47:0] cmd;
		logic [7:0] b;
		logic [7:0] st;
		int w;
		cmd = {$urandom, 16'($urandom)};
		st = 8'($urandom);
		exp_q.push_back(cmd);
		for (int i = 0; i < 6; i++) begin
			host.tx_q.push_back(cmd[47 - 8 * i -: 8]);
			ph_q.push_back(48'(PH_CMD));
		end
		for (int i = 0; i < len; i++) begin
			b = 8'($urandom);
			if (to_host) begin
				feed_q.push_back(b);
				exp_q.push_back(48'({1'b1, PH_DATA_IN, b}));
			end else begin
				host.tx_q.push_back(b);
				ph_q.push_back(48'(PH_DATA_OUT));
				disk_exp.push_back(48'(b));
			end
		end
		exp_q.push_back(48'({1'b1, PH_STATUS, st}));
		exp_q.push_back(48'({1'b1, PH_DONE, DONE_BYTE}));
		host.select(TARGET_ADDR);
		w = 0;
		while (cmd_valid !== 1'b1 && w < 2000) begin
			@(posedge mclk);
			#1;
			w++;
		end
		if (w == 2000) num_errors++;
		// A start with no length still exercises the fall-through to status
		xfer_start = (len > 0) || to_host;
		xfer_to_host = to_host;
		xfer_len = 16'(len);
		@(posedge mclk);
		#1;
		xfer_start = 1'b0;
		status_valid = 1'b1;
		status_byte = st;
		// Status is held until the edge that samples ready high has passed
		w = 0;
		while (status_ready !== 1'b1 && w < 5000) begin
			@(posedge mclk);
			#1;
			w++;
		end
		if (w == 5000) num_errors++;
		@(posedge mclk);
		#1;
		status_valid = 1'b0;
		w = 0;
		while ((busy_n !== 1'b1 || disk_exp.size() > 0) && w < 600) begin
			@(posedge mclk);
			#1;
			w++;
		end
		if (w == 600) num_errors++;
	endtask
	initial begin
		int left;
		void'($urandom(35));
		{rst_n, xfer_start, xfer_to_host, status_valid} = 4'h0;
		{xfer_len, status_byte} = 24'h00_0000;
		repeat (10) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		host.select(TARGET_ADDR + 1);
		check("foreign select", 48'(busy_n), 48'h1);
		repeat (6) begin
			host.tx_q.push_back(8'($urandom));
			ph_q.push_back(48'(PH_CMD));
		end
		host.select(TARGET_ADDR);
		repeat (150) @(posedge mclk);
		#1;
		rst_n = 1'b0;
		repeat (20) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		check("reset", 48'({busy_n, req_n, io_n, cd_n, msg_n, db_n_oe, cmd_valid, db_n_out}),
			48'h7CFF);
		host.tx_q.delete();
		ph_q.delete();
		for (int t = 0; t < 6; t++) run(t[0], t < 2 ? 0 : t < 4 ? 1 : $urandom_range(24, 2));
		left = exp_q.size() + disk_exp.size() + ph_q.size();
		left += feed_q.size() + host.tx_q.size();
		check("leftovers", 48'(left), 48'h0);
		complete_run();
	end
	initial begin
		#300000;
		num_errors++;
		complete_run();
	end
endmodule
`default_nettype wire
